// [src/plds_phy_end.sv]
// PHY end: detects a low power request, resets or disables the interface, re-initializes it.
// Summary of operation
// [RULE1] Isolated link stops, releases lines ending low.
// [RULE2] Non-isolated link releases lines, drives request low.
// [RULE3] Isolated PHY ends lines low, releases, resets.
// [RULE4] Non-isolated PHY drives lines low, resets.
// [RULE5] Isolated disable releases the interface clock.
// [RULE6] Non-isolated disable drives interface clock low.
// [RULE7] Link waits restore time before reasserting.
// [RULE8] Clock restarts within 60 ns of reassertion.
// [RULE9] Isolated restart holds clock low half cycle.
// [RULE10] Restored clock is square wave, fixed period.
// [RULE11] Isolated PHY drives lines low cycle one.
// [RULE12] Isolated link drives low once, cycles one-six.
// [RULE13] Non-isolated PHY drives lines low cycles one-seven.
// [RULE14] Non-isolated link drives low once, request low.
// [RULE15] Cycle eight shows Receive code, data ones.
// [RULE16] Isolated lines released after first Receive cycle.
// [RULE17] Idle code completes init, requests accepted.
// [RULE18] Init runs from reset or disabled state.
// [RULE19] Reset detected after 2.60 to 2.68 us low.
// [RULE20] Disable detected after 26.03 to 26.11 us low.
// [RULE21] Restore interval is at least 15 us.
// [RULE22] Not operational: cancel requests, ignore request line.
// [RULE23] Thresholds timed on the free-running system clock.
// [RULE24] Early reassertion cancels disable, clock keeps running.
`timescale 1ns/1ps
`default_nettype none
module plds_phy_end
  import plds_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    isolated_mode_strap,
  output logic         interface_ready,
  output logic         request_cancel,
  output logic         link_request_bit,
  plds_link_if.phy_mp  lnk
);

  logic              pwr_m;
  logic              pwr_s;
  logic              iso_m;
  logic              iso_s;
  logic              req_m;
  logic              req_s;
  plds_phy_st_t      state_r;
  plds_phy_st_t      state_nxt;
  logic [CNT_W-1:0]  low_cnt_r;
  logic              clk_run_r;
  logic              clk_r;
  logic              clk_oe_n_r;
  logic [1:0]        half_cnt_r;
  logic              clk_rise;
  logic [CYC_W-1:0]  init_cyc_r;
  logic [CYC_W-1:0]  next_cyc;
  logic [CTRL_W-1:0] ctrl_r;
  logic [DATA_W-1:0] data_r;
  logic              line_oe_n_r;
  logic              ready_r;
  logic              cancel_r;
  logic              req_bit_r;
  logic              entering_reset;

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_m <= 1'b0;
      pwr_s <= 1'b0;
      // The mode is unknown until synced, so the pins start out released.
      iso_m <= 1'b1;
      iso_s <= 1'b1;
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else begin
      pwr_m <= lnk.link_power_request;
      pwr_s <= pwr_m;
      iso_m <= isolated_mode_strap;
      iso_s <= iso_m;
      req_m <= lnk.link_request_line;
      req_s <= req_m;
    end
  end

  // The low timer runs on the system clock, so it keeps counting with the
  // interface clock stopped. A pulsed request is not supported: any high
  // sample restarts the measurement.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (pwr_s) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != DISABLE_DETECT_CYC) begin
      low_cnt_r <= low_cnt_r + 12'h001; // [RULE23]
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PHY_OPER: begin
        if (low_cnt_r == RESET_DETECT_CYC) begin
          state_nxt = PHY_RESET; // [RULE19]
        end
      end
      PHY_INIT: begin
        if (low_cnt_r == RESET_DETECT_CYC) begin
          state_nxt = PHY_RESET; // [RULE19]
        end else if (clk_rise && next_cyc == IDLE_CYC) begin
          state_nxt = PHY_OPER; // [RULE17]
        end
      end
      PHY_RESET: begin
        if (pwr_s) begin
          state_nxt = PHY_INIT; // [RULE18] [RULE24]
        end else if (low_cnt_r == DISABLE_DETECT_CYC) begin
          state_nxt = PHY_DISABLED; // [RULE20]
        end
      end
      PHY_DISABLED: begin
        if (pwr_s) begin
          state_nxt = PHY_INIT; // [RULE18]
        end
      end
    endcase
  end

  assign entering_reset = (state_r != PHY_RESET) && (state_nxt == PHY_RESET);
  assign next_cyc       = init_cyc_r + 4'h1;

  // Hardware reset leaves the interface disabled with the clock stopped.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= PHY_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Interface clock divider. A restart always begins low for one half
  // period, which gives the isolated case its leading half cycle.
  assign clk_rise = clk_run_r && !clk_r && (half_cnt_r == IFCLK_HALF_CYC - 2'h1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_run_r  <= 1'b0;
      clk_r      <= 1'b0;
      half_cnt_r <= '0;
      clk_oe_n_r <= 1'b1;
    end else begin
      clk_run_r  <= state_nxt != PHY_DISABLED; // [RULE8] [RULE24]
      clk_oe_n_r <= (state_nxt == PHY_DISABLED) && iso_s; // [RULE5] [RULE6]
      if (!clk_run_r) begin
        clk_r      <= 1'b0; // [RULE6] [RULE9]
        half_cnt_r <= '0;
      end else if (half_cnt_r == IFCLK_HALF_CYC - 2'h1) begin
        clk_r      <= !clk_r; // [RULE10]
        half_cnt_r <= '0;
      end else begin
        half_cnt_r <= half_cnt_r + 2'h1;
      end
    end
  end

  // Interface clock cycles since reassertion; cycle n starts at the n-th rise.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_cyc_r <= '0;
    end else if (state_r != PHY_INIT) begin
      init_cyc_r <= '0;
    end else if (clk_rise && init_cyc_r != 4'hF) begin
      init_cyc_r <= next_cyc;
    end
  end

  // Control and data lines change only with a rising interface clock edge
  // during init, so the link sees whole cycles.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r      <= CODE_IDLE;
      data_r      <= '0;
      line_oe_n_r <= 1'b1;
    end else if (entering_reset) begin
      ctrl_r      <= CODE_IDLE; // [RULE3] [RULE4]
      data_r      <= '0;
      line_oe_n_r <= 1'b0;
    end else if (state_r == PHY_RESET || state_r == PHY_DISABLED) begin
      ctrl_r      <= CODE_IDLE;
      data_r      <= '0;
      line_oe_n_r <= iso_s; // [RULE3] [RULE4]
    end else if (state_r == PHY_INIT && clk_rise) begin
      if (next_cyc < RECEIVE_CYC) begin
        ctrl_r      <= CODE_IDLE;
        data_r      <= '0;
        line_oe_n_r <= iso_s ? (next_cyc != ISO_LOW_CYC) : (next_cyc > NONISO_LAST_LOW); // [RULE11] [RULE13]
      end else if (next_cyc < RECEIVE_CYC + RECEIVE_HOLD_CYC) begin
        ctrl_r      <= CODE_RECEIVE; // [RULE15]
        data_r      <= DATA_ONES;
        line_oe_n_r <= iso_s && (next_cyc != RECEIVE_CYC); // [RULE16]
      end else begin
        ctrl_r      <= CODE_IDLE; // [RULE17]
        data_r      <= '0;
        line_oe_n_r <= 1'b0;
      end
    end
  end

  // Requests count only while operational; leaving operation cancels them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ready_r   <= 1'b0;
      cancel_r  <= 1'b0;
      req_bit_r <= 1'b0;
    end else begin
      ready_r   <= state_nxt == PHY_OPER; // [RULE17]
      cancel_r  <= (state_r == PHY_OPER) && (state_nxt != PHY_OPER); // [RULE22]
      req_bit_r <= req_s && (state_r == PHY_OPER); // [RULE22]
    end
  end

  assign lnk.phy_clk_o     = clk_r;
  assign lnk.phy_clk_oe_n  = clk_oe_n_r;
  assign lnk.phy_ctrl_o    = ctrl_r;
  assign lnk.phy_ctrl_oe_n = line_oe_n_r;
  assign lnk.phy_data_o    = data_r;
  assign lnk.phy_data_oe_n = line_oe_n_r;
  assign interface_ready   = ready_r;
  assign request_cancel    = cancel_r;
  assign link_request_bit  = req_bit_r;

endmodule
`default_nettype wire

// [src/plds_pkg.sv]
// Shared constants, codes and state types for the link power sequencing ends.
`default_nettype none
package plds_pkg;

  // System clock of both ends.
  localparam int CLK_PERIOD_PS = 8000;

  // Time-to-cycle conversions; least times round up, longest times round down.
  function automatic int cyc_up(input int ps);
    cyc_up = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (cyc_up < 1) cyc_up = 1;
  endfunction

  function automatic int cyc_dn(input int ps);
    cyc_dn = ps / CLK_PERIOD_PS;
    if (cyc_dn < 1) cyc_dn = 1;
  endfunction

  // Line and counter widths.
  localparam int CTRL_W = 2;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 12;
  localparam int CYC_W  = 4;

  // Control line codes and the Receive data pattern.
  localparam logic [CTRL_W-1:0] CODE_IDLE    = 2'h0;
  localparam logic [CTRL_W-1:0] CODE_RECEIVE = 2'h2;
  localparam logic [DATA_W-1:0] DATA_ONES    = 8'hFF;

  // Detection windows for a low power request, plus restore, clock restart and link stop times.
  localparam int RESET_DETECT_MIN_NS   = 2600;
  localparam int RESET_DETECT_MAX_NS   = 2680;
  localparam int DISABLE_DETECT_MIN_NS = 26030;
  localparam int DISABLE_DETECT_MAX_NS = 26110;
  localparam int RESTORE_MIN_NS        = 15000;
  localparam int CLK_ACTIVATE_MAX_NS   = 60;
  localparam int LINK_STOP_MAX_NS      = 1000000;

  localparam logic [CNT_W-1:0] RESET_DETECT_CYC   = CNT_W'(cyc_up(RESET_DETECT_MIN_NS * 1000));
  localparam logic [CNT_W-1:0] DISABLE_DETECT_CYC = CNT_W'(cyc_up(DISABLE_DETECT_MIN_NS * 1000));
  localparam logic [CNT_W-1:0] LINK_LOW_MIN_CYC   =
    CNT_W'(cyc_up((RESET_DETECT_MAX_NS + RESTORE_MIN_NS) * 1000));
  localparam int CLK_ACTIVATE_MAX_CYC = cyc_dn(CLK_ACTIVATE_MAX_NS * 1000);

  // Interface clock: nominal period, half period derived from the system clock.
  localparam int IFCLK_PERIOD_PS = 20345;
  localparam logic [1:0] IFCLK_HALF_CYC = 2'(cyc_up(IFCLK_PERIOD_PS / 2));

  // Initialization cycle numbers, counted in interface clock cycles.
  localparam logic [CYC_W-1:0] ISO_LOW_CYC       = 4'h1;
  localparam logic [CYC_W-1:0] NONISO_LAST_LOW   = 4'h7;
  localparam logic [CYC_W-1:0] RECEIVE_CYC       = 4'h8;
  localparam logic [CYC_W-1:0] RECEIVE_HOLD_CYC  = 4'h2;
  localparam logic [CYC_W-1:0] IDLE_CYC          = 4'hA;
  localparam logic [CYC_W-1:0] LINK_DRIVE_CYC    = 4'h2;
  localparam logic [CYC_W-1:0] LINK_WINDOW_CYC   = 4'h6;

  typedef enum logic [1:0] {PHY_OPER, PHY_RESET, PHY_DISABLED, PHY_INIT} plds_phy_st_t;
  typedef enum logic [1:0] {LNK_DOWN, LNK_INIT, LNK_OPER} plds_lnk_st_t;

endpackage
`default_nettype wire

// [src/plds_link_if.sv]
// Pin bundle between the PHY end and the link controller end, with wire resolution.
`timescale 1ns/1ps
`default_nettype none
interface plds_link_if;
  import plds_pkg::*;

  logic              link_power_request;
  logic              phy_clk_o;
  logic              phy_clk_oe_n;
  logic [CTRL_W-1:0] phy_ctrl_o;
  logic              phy_ctrl_oe_n;
  logic [DATA_W-1:0] phy_data_o;
  logic              phy_data_oe_n;
  logic [CTRL_W-1:0] link_ctrl_o;
  logic              link_ctrl_oe_n;
  logic [DATA_W-1:0] link_data_o;
  logic              link_data_oe_n;
  logic              link_req_o;
  logic              link_req_oe_n;

  // Resolved line levels; an undriven line settles low, as its holder would.
  logic              link_side_clock_out;
  logic [CTRL_W-1:0] interface_control_lines;
  logic [DATA_W-1:0] data_lines;
  logic              link_request_line;

  assign link_side_clock_out     = !phy_clk_oe_n & phy_clk_o;
  assign interface_control_lines = !phy_ctrl_oe_n ? phy_ctrl_o :
                                   (!link_ctrl_oe_n ? link_ctrl_o : '0);
  assign data_lines              = !phy_data_oe_n ? phy_data_o :
                                   (!link_data_oe_n ? link_data_o : '0);
  assign link_request_line       = !link_req_oe_n & link_req_o;

  modport phy_mp (
    input  link_power_request,
    input  link_request_line,
    output phy_clk_o,
    output phy_clk_oe_n,
    output phy_ctrl_o,
    output phy_ctrl_oe_n,
    output phy_data_o,
    output phy_data_oe_n
  );

  modport link_mp (
    input  link_side_clock_out,
    input  interface_control_lines,
    input  data_lines,
    output link_power_request,
    output link_ctrl_o,
    output link_ctrl_oe_n,
    output link_data_o,
    output link_data_oe_n,
    output link_req_o,
    output link_req_oe_n
  );
endinterface
`default_nettype wire

// [src/plds_link_end.sv]
// Link controller end: drives the power request and its lines through reset and init.
`timescale 1ns/1ps
`default_nettype none
module plds_link_end
  import plds_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     rst,
  input  wire logic     isolated_mode,
  input  wire logic     power_on_cmd,
  input  wire logic     request_bit,
  output logic          interface_ready,
  plds_link_if.link_mp  lnk
);

  logic              clk_m;
  logic              clk_s;
  logic              clk_d;
  logic [CTRL_W-1:0] ctrl_m;
  logic [CTRL_W-1:0] ctrl_s;
  logic              clk_rise;
  plds_lnk_st_t      state_r;
  plds_lnk_st_t      state_nxt;
  logic [CNT_W-1:0]  low_cnt_r;
  logic [CYC_W-1:0]  cyc_r;
  logic [CYC_W-1:0]  cyc_nxt;
  logic              rx_seen_r;
  logic              idle_seen_r;
  logic              pwr_req_r;
  logic              ctrl_oe_n_r;
  logic              req_o_r;
  logic              req_oe_n_r;
  logic              ready_r;
  logic              going_down;
  logic              drive_low;

  // Pin synchronisers; the second stage is read, plus a third clock stage for edge detection.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_m  <= 1'b0;
      clk_s  <= 1'b0;
      clk_d  <= 1'b0;
      ctrl_m <= '0;
      ctrl_s <= '0;
    end else begin
      clk_m  <= lnk.link_side_clock_out;
      clk_s  <= clk_m;
      clk_d  <= clk_s;
      ctrl_m <= lnk.interface_control_lines;
      ctrl_s <= ctrl_m;
    end
  end

  assign clk_rise = clk_s & !clk_d;

  always_comb begin
    state_nxt = state_r;
    cyc_nxt   = cyc_r;
    unique case (state_r)
      LNK_DOWN: begin
        cyc_nxt = '0;
        // Hold the request low long enough for reset detection plus restore.
        if (power_on_cmd && low_cnt_r == LINK_LOW_MIN_CYC) begin // [RULE7] [RULE21]
          state_nxt = LNK_INIT;
        end
      end
      LNK_INIT: begin
        if (clk_rise && cyc_r != 4'hF) begin
          cyc_nxt = cyc_r + 4'h1;
        end
        if (clk_rise && rx_seen_r && idle_seen_r && ctrl_s == CODE_IDLE) begin
          state_nxt = LNK_OPER; // [RULE17]
        end
      end
      LNK_OPER: begin
      end
    endcase
    if (!power_on_cmd && state_r != LNK_DOWN) begin
      state_nxt = LNK_DOWN;
    end
  end

  assign going_down = (state_r != LNK_DOWN) && (state_nxt == LNK_DOWN);
  // One low cycle inside the first six, away from the PHY's own low cycle.
  assign drive_low  = (going_down && isolated_mode) ||
                      (state_nxt == LNK_INIT && cyc_nxt == LINK_DRIVE_CYC); // [RULE12] [RULE14]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r   <= LNK_DOWN;
      cyc_r     <= '0;
      low_cnt_r <= '0;
      rx_seen_r <= 1'b0;
      idle_seen_r <= 1'b0;
      pwr_req_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cyc_r     <= cyc_nxt;
      pwr_req_r <= state_nxt != LNK_DOWN;
      if (state_nxt != LNK_DOWN) begin
        low_cnt_r <= '0;
      end else if (low_cnt_r != LINK_LOW_MIN_CYC) begin
        low_cnt_r <= low_cnt_r + 12'h001;
      end
      rx_seen_r <= (state_nxt == LNK_INIT) && (rx_seen_r || ctrl_s == CODE_RECEIVE);
      // Released lines read as Idle, so Idle is trusted only at the second rise showing it.
      idle_seen_r <= (state_nxt == LNK_INIT) && rx_seen_r && (ctrl_s == CODE_IDLE) &&
                     (idle_seen_r || clk_rise);
    end
  end

  // Activity stops at once on deassertion, well inside the allowed stop time.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_oe_n_r <= 1'b1;
      req_o_r     <= 1'b0;
      req_oe_n_r  <= 1'b1;
      ready_r     <= 1'b0;
    end else begin
      ctrl_oe_n_r <= !drive_low; // [RULE1] [RULE2]
      req_o_r     <= (state_nxt == LNK_OPER) && request_bit;
      req_oe_n_r  <= !(drive_low || state_nxt == LNK_OPER ||
                       (!isolated_mode && state_nxt != LNK_OPER)); // [RULE1] [RULE2] [RULE14]
      ready_r     <= state_nxt == LNK_OPER;
    end
  end

  assign lnk.link_power_request = pwr_req_r;
  assign lnk.link_ctrl_o        = '0;
  assign lnk.link_data_o        = '0;
  assign lnk.link_ctrl_oe_n     = ctrl_oe_n_r;
  assign lnk.link_data_oe_n     = ctrl_oe_n_r;
  assign lnk.link_req_o         = req_o_r;
  assign lnk.link_req_oe_n      = req_oe_n_r;
  assign interface_ready        = ready_r;

endmodule
`default_nettype wire

// [tb/plds_asserts.sv]
// Concurrent checks on the pin bundle between the PHY end and the link end.
`timescale 1ns/1ps
`default_nettype none
module plds_asserts
  import plds_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              link_power_request,
  input  wire logic              phy_clk_oe_n,
  input  wire logic [CTRL_W-1:0] phy_ctrl_o,
  input  wire logic              phy_ctrl_oe_n,
  input  wire logic [DATA_W-1:0] phy_data_o,
  input  wire logic [CTRL_W-1:0] link_ctrl_o,
  input  wire logic              link_ctrl_oe_n,
  input  wire logic [DATA_W-1:0] link_data_o,
  input  wire logic              link_data_oe_n,
  input  wire logic              link_side_clock_out,
  input  wire logic              link_request_line
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [12:0] low_cnt_r;
  logic        rx_drv;

  assign rx_drv = !phy_ctrl_oe_n && (phy_ctrl_o == CODE_RECEIVE);

  // Counts from the pin itself, so the PHY's own synchronizer delay is inside the margins.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 13'h0000;
    end else if (link_power_request) begin
      low_cnt_r <= 13'h0000;
    end else if (low_cnt_r != 13'h1FFF) begin
      low_cnt_r <= low_cnt_r + 13'h0001;
    end
  end

  property p_clk_high;
    $rose(link_side_clock_out) && link_power_request |=> link_side_clock_out ##1 !link_side_clock_out;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("interface clock high phase wrong");
  property p_clk_low;
    $fell(link_side_clock_out) && link_power_request |=> !link_side_clock_out ##1 link_side_clock_out;
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("interface clock low phase wrong");
  property p_clk_start;
    $fell(phy_clk_oe_n) && link_power_request |-> !link_side_clock_out ##1 !link_side_clock_out
      ##1 link_side_clock_out;
  endproperty
  a_clk_start: assert property (p_clk_start)
    else $error("restart low half cycle wrong");
  property p_activate;
    $rose(link_power_request) |-> ##[1:7] link_side_clock_out;
  endproperty
  a_activate: assert property (p_activate)
    else $error("interface clock not restarted");
  property p_reset_lines;
    low_cnt_r >= 13'h14F |-> phy_ctrl_oe_n || (phy_ctrl_o == 2'h0 && phy_data_o == 8'h00);
  endproperty
  a_reset_lines: assert property (p_reset_lines)
    else $error("lines not low in reset");
  property p_disable;
    low_cnt_r >= 13'hCC0 |-> !link_side_clock_out;
  endproperty
  a_disable: assert property (p_disable)
    else $error("interface clock not stopped");
  property p_no_early_disable;
    low_cnt_r == 13'hCA8 |-> ##[1:4] link_side_clock_out;
  endproperty
  a_no_early_disable: assert property (p_no_early_disable)
    else $error("clock stopped early");
  property p_receive_data;
    rx_drv |-> phy_data_o == DATA_ONES;
  endproperty
  a_receive_data: assert property (p_receive_data)
    else $error("receive data not all ones");
  property p_idle_next;
    $fell(rx_drv) && link_power_request |-> ##[0:8]
      (!phy_ctrl_oe_n && phy_ctrl_o == CODE_IDLE && phy_data_o == 8'h00);
  endproperty
  a_idle_next: assert property (p_idle_next)
    else $error("idle did not follow receive");
  property p_link_release;
    $fell(link_power_request) |-> ##[1:3] (link_ctrl_oe_n && link_data_oe_n && !link_request_line);
  endproperty
  a_link_release: assert property (p_link_release)
    else $error("link did not release");
  property p_link_zero;
    !link_ctrl_oe_n || !link_data_oe_n |-> link_ctrl_o == 2'h0 && link_data_o == 8'h00;
  endproperty
  a_link_zero: assert property (p_link_zero)
    else $error("link drove nonzero lines");
  property p_restore;
    $rose(link_power_request) |-> low_cnt_r >= 13'h753;
  endproperty
  a_restore: assert property (p_restore)
    else $error("power request low too briefly");

  c_receive: cover property (rx_drv);
  c_disabled: cover property (low_cnt_r == 13'hCC0);
  c_wake: cover property ($rose(link_power_request) && phy_clk_oe_n);
endmodule
`default_nettype wire

// [tb/phy_link_disable_init_seq_bench.sv]
// Bench joining the PHY end and the link end, walking them through reset, disable and init.
`timescale 1ns/1ps
`default_nettype none
module phy_link_disable_init_seq_bench
  import plds_pkg::*;
();
  localparam int CEIL = 30000;
  logic clock, rst, iso, power_on_cmd, request_bit;
  logic phy_ready, cancel, lrb, lnk_ready, prev;
  int   err_count, n_tests, seed, rises, drv, rx_at, rx_drv, lnk_low, req_hi, cnl;
  int   cyc = 0;

  plds_link_if lnk ();
  plds_phy_end plds_phy_end_i (.clock(clock), .rst(rst), .isolated_mode_strap(iso),
    .interface_ready(phy_ready), .request_cancel(cancel), .link_request_bit(lrb), .lnk(lnk));
  plds_link_end plds_link_end_i (.clock(clock), .rst(rst), .isolated_mode(iso),
    .power_on_cmd(power_on_cmd), .request_bit(request_bit), .interface_ready(lnk_ready),
    .lnk(lnk));
  plds_asserts plds_asserts_i (.clock(clock), .rst(rst),
    .link_power_request(lnk.link_power_request), .phy_clk_oe_n(lnk.phy_clk_oe_n),
    .phy_ctrl_o(lnk.phy_ctrl_o), .phy_ctrl_oe_n(lnk.phy_ctrl_oe_n), .phy_data_o(lnk.phy_data_o),
    .link_ctrl_o(lnk.link_ctrl_o), .link_ctrl_oe_n(lnk.link_ctrl_oe_n),
    .link_data_o(lnk.link_data_o), .link_data_oe_n(lnk.link_data_oe_n),
    .link_side_clock_out(lnk.link_side_clock_out), .link_request_line(lnk.link_request_line));

  always #4 clock = ~clock;

  task automatic results();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == CEIL) begin
      err_count++;
      results();
    end
  end

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Falling system edges spent in a phase lasting the given number of interface cycles.
  function automatic int exp_edges(input int if_cycles);
    exp_edges = if_cycles * 2 * int'(IFCLK_HALF_CYC);
  endfunction

  // Interface clock cycles are numbered from the first rise after the request goes high.
  task automatic bring_up(input bit from_dis);
    rises = 0; drv = 0; rx_at = 0; rx_drv = 0; lnk_low = 0; req_hi = 0; prev = 1'b1;
    for (int i = 0; i < 4000 && phy_ready !== 1'b1; i++) begin
      @(negedge clock);
      if (lnk.link_power_request === 1'b1) begin
        if (lnk.link_side_clock_out === 1'b1 && prev !== 1'b1) rises++;
        if (rises inside {[1:7]} && lnk.phy_ctrl_oe_n === 1'b0 && lnk.phy_ctrl_o === 2'h0
            && lnk.phy_data_o === 8'h00) drv++;
        if (lnk.phy_ctrl_oe_n === 1'b0 && lnk.phy_ctrl_o === CODE_RECEIVE) begin
          rx_drv++;
          if (rx_at == 0) rx_at = rises;
        end
        if (rises inside {[1:6]} && lnk.link_ctrl_oe_n === 1'b0) lnk_low++;
        if (lnk.link_request_line !== 1'b0) req_hi++;
      end
      prev = lnk.link_side_clock_out;
    end
    chk_flag(phy_ready, 1'b1);
    chk_cnt(rx_drv, exp_edges(iso ? 1 : int'(RECEIVE_HOLD_CYC)));
    chk_cnt(req_hi, 0);
    chk_flag(lnk_low > 0, 1'b1);
    if (from_dis) begin
      chk_cnt(rx_at, int'(RECEIVE_CYC));
      chk_cnt(drv, exp_edges(iso ? 1 : int'(NONISO_LAST_LOW)));
    end
    for (int i = 0; i < 50 && lnk_ready !== 1'b1; i++) @(negedge clock);
    chk_flag(lnk_ready, 1'b1);
  endtask

  initial begin
    seed = 36348; clock = 1'b0; rst = 1'b1; iso = 1'b0; power_on_cmd = 1'b1;
    request_bit = 1'b0; err_count = 0; n_tests = 0;
    // The second pass resets in mid-run while the interface is operational.
    for (int m = 0; m < 2; m++) begin
      @(negedge clock);
      rst = 1'b1;
      iso = m[0];
      repeat (16) @(negedge clock);
      rst = 1'b0;
      repeat (8) @(negedge clock);
      chk_flag(lnk.phy_clk_oe_n, iso);
      chk_flag(lnk.link_side_clock_out, 1'b0);
      bring_up(1'b1);
      repeat (20) begin
        request_bit = 1'($random(seed));
        repeat (8) @(negedge clock);
        chk_flag(lrb, request_bit);
      end
      request_bit = 1'b1;
      power_on_cmd = 1'b0;
      cnl = 0;
      repeat (16 + ($unsigned($random(seed)) % 200)) @(negedge clock);
      power_on_cmd = 1'b1;
      repeat (400) begin
        @(negedge clock);
        cnl += int'(cancel);
      end
      chk_cnt(cnl, 1);
      chk_flag(phy_ready, 1'b0);
      chk_flag(lrb, 1'b0);
      drv = 0;
      repeat (8) begin
        @(negedge clock);
        drv += int'(lnk.link_side_clock_out);
      end
      chk_flag(drv > 0, 1'b1);
      bring_up(1'b0);
      power_on_cmd = 1'b0;
      repeat (3400) @(negedge clock);
      chk_flag(lnk.phy_clk_oe_n, iso);
      chk_flag(lnk.link_side_clock_out, 1'b0);
      power_on_cmd = 1'b1;
      bring_up(1'b1);
    end
    results();
  end
endmodule
`default_nettype wire
